// >>> pkg/vrc_cfg.svh
// constants for the video output routing control block
// Function
// - output horizontal timing delayed by programmable pixel clock count
// - output vertical timing delayed by programmable whole line count
// - fine horizontal setting adds to the coarse horizontal offset
// - dual-rate output carries re-clocked hd or down-converted sd
// - each sd-or-encoder output picks sd or composite on its own
// - option output picks sd, composite or de-embedded aes audio
// - reduced mode embeds sixteen channels, samples cut to twenty bits
// - full mode embeds twelve channels at twenty-four bits only
// - source selector routes exactly one of three hd inputs
// - selected hd source copied to three primary outputs
// - down-converter input is local hd or left or right neighbour
// - sd video feeds dual-rate selector, encoder and all switches
// - primary outputs ignore the down-converter input choice
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH
`define VRC_SRC_REAR 2'h0
`define VRC_SRC_STAR_A 2'h1
`define VRC_SRC_STAR_B 2'h2
`define VRC_DC_LOCAL 2'h0
`define VRC_DC_LEFT 2'h1
`define VRC_DC_RIGHT 2'h2
`define VRC_OPT_SD 2'h0
`define VRC_OPT_ENC 2'h1
`define VRC_OPT_AES 2'h2
`define VRC_CH_REDUCED 5'h10
`define VRC_CH_FULL 5'h0C
`define VRC_WL_REDUCED 5'h14
`define VRC_WL_FULL 5'h18
`define VRC_CMD_SRC 3'h0
`define VRC_CMD_DC 3'h1
`define VRC_CMD_OUT 3'h2
`define VRC_CMD_AUDIO 3'h3
`define VRC_CMD_HPH 3'h4
`define VRC_CMD_VPH 3'h5
`define VRC_CMD_HFINE 3'h6
`define VRC_FIFO_DEPTH 16
`endif

// >>> pkg/vrc_pkg.sv
// types for the video output routing control block
package vrc_pkg;
   typedef enum logic [2:0] {
      VRC_IDLE = 3'b001,
      VRC_HDLY = 3'b010,
      VRC_RUN = 3'b100
   } vrc_state_e;
endpackage

// >>> src/vrc_fifo.sv
// parameterised fifo for the sd output word stream
`timescale 1ns/10ps
module vrc_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   logic full;
   logic empty;
   assign empty = (wp_q == rp_q);
   assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         wp_q <= '0;
      else if (in_valid_i && !full)
         wp_q <= wp_q + 1'b1;
   end
   always_ff @(posedge mclk_i)
   begin
      if (in_valid_i && !full)
         mem_q[wp_q[AW-1:0]] <= in_data_i;
   end
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rp_q <= '0;
      else if (out_ready_i && !empty)
         rp_q <= rp_q + 1'b1;
   end
endmodule

// >>> src/vrc_top.sv
// routing, phase offset and audio mode control for the video card
`timescale 1ns/10ps
`include "vrc_cfg.svh"
module vrc_top #(
   parameter int W = 10,
   parameter int HW = 12,
   parameter int VW = 11,
   parameter int FW = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // controller command port
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_sel_i,
   input wire logic [HW-1:0] cmd_data_i,
   // hd inputs and neighbour inputs
   input wire logic [W-1:0] rear_hd_i,
   input wire logic [W-1:0] star_a_hd_i,
   input wire logic [W-1:0] star_b_hd_i,
   input wire logic [W-1:0] left_hd_i,
   input wire logic [W-1:0] right_hd_i,
   // other sources
   input wire logic [W-1:0] enc_i,
   input wire logic [W-1:0] aes_i,
   input wire logic [W-1:0] sd_conv_i,
   input wire logic sd_conv_valid_i,
   // input timing
   input wire logic sol_i,
   input wire logic sof_i,
   // primary outputs
   output logic [W-1:0] first_primary_output_o,
   output logic [W-1:0] second_primary_output_o,
   output logic [W-1:0] third_primary_output_o,
   // down-converter feed and audio mode
   output logic [W-1:0] dc_in_o,
   output logic [4:0] audio_channels_o,
   output logic [4:0] audio_word_bits_o,
   // selectable outputs
   output logic [W-1:0] dual_rate_connector_o,
   output logic [W-1:0] first_sd_or_encoder_connector_o,
   output logic [W-1:0] second_sd_or_encoder_connector_o,
   output logic [W-1:0] option_connector_o,
   output logic [W-1:0] enc_feed_o,
   // sd stream back-pressure and output timing
   output logic sd_conv_ready_o,
   output logic sol_o,
   output logic sof_o,
   output logic timing_run_o
);
   logic [1:0] src_sel_q;
   logic [1:0] dc_sel_q;
   logic dual_rate_output_select_q;
   logic first_sd_encoder_output_select_q;
   logic second_sd_encoder_output_select_q;
   logic [1:0] option_output_select_q;
   logic reduced_q;
   logic [HW-1:0] hph_q;
   logic [VW-1:0] vph_q;
   logic [FW-1:0] hfine_q;
   logic [W-1:0] hd_q;
   logic [W-1:0] sd_word;
   logic sd_valid;
   logic [W-1:0] sd_q;
   logic [HW:0] hcnt_q;
   logic [VW-1:0] vcnt_q;
   logic vpend_q;
   vrc_pkg::vrc_state_e st_q;
   logic [HW:0] htot;

   function automatic logic [W-1:0] pick3(input logic [1:0] s,
      input logic [W-1:0] a, input logic [W-1:0] b, input logic [W-1:0] c);
      // illegal code 3 falls back to the first source so one always drives
      unique case (s)
         2'h1: pick3 = b;
         2'h2: pick3 = c;
         default: pick3 = a;
      endcase
   endfunction

   // settings only move on a command aimed at them
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         src_sel_q <= `VRC_SRC_REAR;
         dc_sel_q <= `VRC_DC_LOCAL;
         dual_rate_output_select_q <= 1'b0;
         first_sd_encoder_output_select_q <= 1'b0;
         second_sd_encoder_output_select_q <= 1'b0;
         option_output_select_q <= `VRC_OPT_SD;
         reduced_q <= 1'b1;
      end
      else if (cmd_valid_i)
      begin
         unique case (cmd_sel_i)
            `VRC_CMD_SRC: src_sel_q <= cmd_data_i[1:0];
            `VRC_CMD_DC: dc_sel_q <= cmd_data_i[1:0];
            `VRC_CMD_OUT:
            begin
               dual_rate_output_select_q <= cmd_data_i[0];
               first_sd_encoder_output_select_q <= cmd_data_i[1];
               second_sd_encoder_output_select_q <= cmd_data_i[2];
               option_output_select_q <= cmd_data_i[4:3];
            end
            `VRC_CMD_AUDIO: reduced_q <= cmd_data_i[0];
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         hph_q <= '0;
         vph_q <= '0;
         hfine_q <= '0;
      end
      else if (cmd_valid_i)
      begin
         if (cmd_sel_i == `VRC_CMD_HPH)
            hph_q <= cmd_data_i;
         if (cmd_sel_i == `VRC_CMD_VPH)
            vph_q <= cmd_data_i[VW-1:0];
         if (cmd_sel_i == `VRC_CMD_HFINE)
            hfine_q <= cmd_data_i[FW-1:0];
      end
   end

   // re-clocked hd path, unaffected by the down-converter choice
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         hd_q <= '0;
      else
         hd_q <= pick3(src_sel_q, rear_hd_i, star_a_hd_i, star_b_hd_i);
   end
   assign first_primary_output_o = hd_q;
   assign second_primary_output_o = hd_q;
   assign third_primary_output_o = hd_q;

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         dc_in_o <= '0;
      else
         dc_in_o <= pick3(dc_sel_q, hd_q, left_hd_i, right_hd_i);
   end

   // sixteen channels at 24 bits is never offered
   assign audio_channels_o =
      reduced_q ? `VRC_CH_REDUCED : `VRC_CH_FULL;
   assign audio_word_bits_o =
      reduced_q ? `VRC_WL_REDUCED : `VRC_WL_FULL;

   // sd stream buffered so a stalled sink pushes back on the converter
   vrc_fifo #(
      .W(W),
      .D(`VRC_FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(sd_conv_valid_i),
      .in_ready_o(sd_conv_ready_o),
      .in_data_i(sd_conv_i),
      .out_valid_o(sd_valid),
      .out_ready_i(timing_run_o),
      .out_data_o(sd_word)
   );

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         sd_q <= '0;
      else if (sd_valid && timing_run_o)
         sd_q <= sd_word;
   end

   // one sd word drives every switch so they never disagree
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         dual_rate_connector_o <= '0;
         first_sd_or_encoder_connector_o <= '0;
         second_sd_or_encoder_connector_o <= '0;
         option_connector_o <= '0;
         enc_feed_o <= '0;
      end
      else
      begin
         enc_feed_o <= sd_q;
         dual_rate_connector_o <=
            dual_rate_output_select_q ? sd_q : hd_q;
         first_sd_or_encoder_connector_o <=
            first_sd_encoder_output_select_q ? enc_i : sd_q;
         second_sd_or_encoder_connector_o <=
            second_sd_encoder_output_select_q ? enc_i : sd_q;
         option_connector_o <=
            pick3(option_output_select_q, sd_q, enc_i, aes_i);
      end
   end

   // output timing: wait whole lines, then coarse plus fine pixels
   assign htot = {1'b0, hph_q} + {{(HW+1-FW){1'b0}}, hfine_q};

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_q <= vrc_pkg::VRC_IDLE;
         vcnt_q <= '0;
         hcnt_q <= '0;
         vpend_q <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            vrc_pkg::VRC_IDLE:
               if (sof_i)
               begin
                  vcnt_q <= vph_q;
                  vpend_q <= 1'b1;
                  st_q <= vrc_pkg::VRC_HDLY;
                  hcnt_q <= '0;
               end
            vrc_pkg::VRC_HDLY:
            begin
               if (vpend_q)
               begin
                  if (vcnt_q == '0)
                  begin
                     vpend_q <= 1'b0;
                     hcnt_q <= htot;
                  end
                  else if (sol_i)
                     vcnt_q <= vcnt_q - 1'b1;
               end
               else if (hcnt_q == '0)
                  st_q <= vrc_pkg::VRC_RUN;
               else
                  hcnt_q <= hcnt_q - 1'b1;
            end
            vrc_pkg::VRC_RUN:
               if (sof_i)
               begin
                  vcnt_q <= vph_q;
                  vpend_q <= 1'b1;
                  st_q <= vrc_pkg::VRC_HDLY;
               end
         endcase
      end
   end
   assign timing_run_o = (st_q == vrc_pkg::VRC_RUN);

   // delayed line mark trails a line mark by coarse plus fine pixels; the frame mark trails its last counted line by that plus two cycles
   logic [HW:0] lcnt_q;
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         lcnt_q <= '0;
         sol_o <= 1'b0;
         sof_o <= 1'b0;
      end
      else
      begin
         sof_o <= (st_q == vrc_pkg::VRC_HDLY) && !vpend_q
            && (hcnt_q == '0);
         sol_o <= 1'b0;
         // a zero offset passes the line mark straight through
         if (sol_i)
         begin
            lcnt_q <= htot;
            sol_o <= (htot == '0);
         end
         else if (lcnt_q != '0)
         begin
            lcnt_q <= lcnt_q - 1'b1;
            sol_o <= (lcnt_q == {{HW{1'b0}}, 1'b1});
         end
      end
   end
endmodule

// >>> dv/vrc_ctl_model.sv
// frame controller model issuing routing commands
`timescale 1ns/10ps
module vrc_ctl #(
   parameter int HW = 12
) (
   input wire logic mclk_i,
   output logic cmd_valid_o,
   output logic [2:0] cmd_sel_o,
   output logic [HW-1:0] cmd_data_o
);
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_sel_o = 3'h7;
      cmd_data_o = '0;
   end
   // one command per call; released lines show the inverse, not stale data
   task automatic send(input logic [2:0] sel, input logic [HW-1:0] d);
      @(negedge mclk_i);
      cmd_valid_o = 1'b1;
      cmd_sel_o = sel;
      cmd_data_o = d;
      @(negedge mclk_i);
      cmd_valid_o = 1'b0;
      cmd_sel_o = ~sel;
      cmd_data_o = ~d;
   endtask
endmodule

// >>> dv/vrc_top_assertions.sv
// concurrent checks on the routing control ports
`timescale 1ns/10ps
`include "vrc_cfg.svh"
module vrc_chk #(
   parameter int W = 10,
   parameter int HW = 12
) (
   // clock, reset, commands and sources
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_sel_i,
   input wire logic [HW-1:0] cmd_data_i,
   input wire logic [W-1:0] rear_hd_i,
   input wire logic [W-1:0] star_a_hd_i,
   input wire logic [W-1:0] star_b_hd_i,
   input wire logic [W-1:0] left_hd_i,
   input wire logic [W-1:0] enc_i,
   input wire logic [W-1:0] aes_i,
   // watched outputs
   input wire logic [W-1:0] first_primary_output_o,
   input wire logic [W-1:0] third_primary_output_o,
   input wire logic [W-1:0] dc_in_o,
   input wire logic [4:0] audio_channels_o,
   input wire logic [4:0] audio_word_bits_o,
   input wire logic [W-1:0] dual_rate_connector_o,
   input wire logic [W-1:0] first_sd_or_encoder_connector_o,
   input wire logic [W-1:0] option_connector_o,
   input wire logic sof_o
);
   logic [1:0] src_q, dc_q, opt_q, quiet_q;
   logic dual_q, se1_q;
   logic [W-1:0] pick;
   logic [6*W-1:0] ins_q;
   wire [6*W-1:0] ins = {rear_hd_i, star_a_hd_i, star_b_hd_i,
      left_hd_i, enc_i, aes_i};
   assign pick = src_q == 2'h1 ? star_a_hd_i :
      src_q == 2'h2 ? star_b_hd_i : rear_hd_i;
   // shadow of the settings, kept from the command port alone
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         {src_q, dc_q, opt_q, dual_q, se1_q} <= 8'h00;
      end
      else if (cmd_valid_i && cmd_sel_i == `VRC_CMD_SRC)
         src_q <= cmd_data_i[1:0];
      else if (cmd_valid_i && cmd_sel_i == `VRC_CMD_DC)
         dc_q <= cmd_data_i[1:0];
      else if (cmd_valid_i && cmd_sel_i == `VRC_CMD_OUT)
         {opt_q, se1_q, dual_q} <= {cmd_data_i[4:3], cmd_data_i[1:0]};
   end
   // three quiet edges cover the two-stage hd path with margin
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         quiet_q <= 2'h0;
      else if (cmd_valid_i || ins != ins_q)
         quiet_q <= 2'h0;
      else if (quiet_q != 2'h3)
         quiet_q <= quiet_q + 2'h1;
   end
   always_ff @(posedge mclk_i)
      ins_q <= ins;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   chk_prim_pick: assert property (
      quiet_q == 2'h3 |-> first_primary_output_o == pick)
      else $error("primary output not the picked source");
   chk_prim_copy: assert property (
      first_primary_output_o == third_primary_output_o)
      else $error("primary outputs differ");
   chk_dual_hd: assert property (
      quiet_q == 2'h3 && !dual_q |-> dual_rate_connector_o == pick)
      else $error("dual-rate output not hd");
   chk_sdenc_enc: assert property (
      quiet_q == 2'h3 && se1_q |-> first_sd_or_encoder_connector_o == enc_i)
      else $error("sd or encoder output not encoder");
   chk_opt_aes: assert property (
      quiet_q == 2'h3 && opt_q == 2'h2 |-> option_connector_o == aes_i)
      else $error("option output not audio");
   chk_dc_left: assert property (
      quiet_q == 2'h3 && dc_q == 2'h1 |-> dc_in_o == left_hd_i)
      else $error("converter input not left");
   chk_audio_mode: assert property (
      audio_channels_o == `VRC_CH_REDUCED ?
      audio_word_bits_o == `VRC_WL_REDUCED :
      audio_channels_o == `VRC_CH_FULL && audio_word_bits_o == `VRC_WL_FULL)
      else $error("illegal audio mode");
   chk_audio_hold: assert property (
      !$past(cmd_valid_i) |-> $stable({audio_channels_o, audio_word_bits_o}))
      else $error("audio mode moved without command");
   chk_sof_pulse: assert property (sof_o |=> !sof_o)
      else $error("frame mark longer than one cycle");
   cover property (quiet_q == 2'h3 && opt_q == 2'h2);
   cover property (quiet_q == 2'h3 && dc_q == 2'h1);
   cover property (sof_o);
endmodule
bind vrc_top vrc_chk #(.W(W), .HW(HW)) chk_u (.*);

// >>> dv/tb.sv
// self-checking bench for the routing control block
`timescale 1ns/10ps
`include "vrc_cfg.svh"
module tb;
   logic mclk_i, rst_b_i, cmd_valid_i, sd_conv_valid_i, sol_i, sof_i;
   logic [2:0] cmd_sel_i;
   logic [11:0] cmd_data_i;
   logic [9:0] rear_hd_i, star_a_hd_i, star_b_hd_i, left_hd_i, right_hd_i;
   logic [9:0] enc_i, aes_i, sd_conv_i, dc_in_o, enc_feed_o, e;
   logic [9:0] first_primary_output_o, second_primary_output_o;
   logic [9:0] third_primary_output_o, dual_rate_connector_o;
   logic [9:0] first_sd_or_encoder_connector_o, option_connector_o;
   logic [9:0] second_sd_or_encoder_connector_o;
   logic [4:0] audio_channels_o, audio_word_bits_o;
   logic sd_conv_ready_o, sol_o, sof_o, timing_run_o, early;
   int errors, n_tests, i, d0, d1;
   vrc_top dut_u (.*);
   vrc_ctl ctl_u (.mclk_i, .cmd_valid_o(cmd_valid_i),
      .cmd_sel_o(cmd_sel_i), .cmd_data_o(cmd_data_i));
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmd(input logic [2:0] s, input logic [11:0] d);
      ctl_u.send(s, d);
      repeat (4) @(negedge mclk_i);
   endtask
   // frame mark, then nsol line marks; d counts to the delayed frame mark
   task automatic frame(input int nsol, output int d);
      early = 1'b0;
      d = 0;
      @(negedge mclk_i) sof_i = 1'b1;
      @(negedge mclk_i) sof_i = 1'b0;
      for (int k = 0; k < nsol; k++)
      begin
         repeat (20) @(negedge mclk_i) early |= sof_o;
         sol_i = 1'b1;
         @(negedge mclk_i) sol_i = 1'b0;
      end
      while (!sof_o && d < 60)
         @(negedge mclk_i) d++;
      if (d == 60)
         check(12'h000, 12'h001);
   endtask
   initial
   begin
      {errors, n_tests} = 0;
      {rst_b_i, sol_i, sof_i, sd_conv_valid_i} = 4'h0;
      {rear_hd_i, star_a_hd_i, star_b_hd_i} = {10'h101, 10'h102, 10'h103};
      {left_hd_i, right_hd_i, enc_i} = {10'h104, 10'h105, 10'h106};
      {aes_i, sd_conv_i} = {10'h107, 10'h155};
      repeat (8) @(negedge mclk_i);
      rst_b_i = 1'b1;
      check(audio_channels_o, `VRC_CH_REDUCED);
      // timing idle keeps the fifo from draining, so it must refuse at 16
      sd_conv_valid_i = 1'b1;
      for (i = 0; i < 40 && sd_conv_ready_o; i++)
         @(negedge mclk_i);
      sd_conv_valid_i = 1'b0;
      check(12'(i), `VRC_FIFO_DEPTH);
      for (int c = 0; c < 4; c++)
      begin
         cmd(`VRC_CMD_SRC, 12'(c));
         e = c == 1 ? star_a_hd_i : c == 2 ? star_b_hd_i : rear_hd_i;
         check(first_primary_output_o, e);
         check(second_primary_output_o, e);
         check(third_primary_output_o, e);
      end
      cmd(`VRC_CMD_SRC, 12'h002);
      for (int c = 0; c < 3; c++)
      begin
         cmd(`VRC_CMD_DC, 12'(c));
         e = c == 1 ? left_hd_i : c == 2 ? right_hd_i : star_b_hd_i;
         check(dc_in_o, e);
         check(first_primary_output_o, star_b_hd_i);
      end
      for (int k = 0; k < 4; k++)
      begin
         cmd(`VRC_CMD_OUT, {7'h00, 2'(k), ~k[0], k[0], k[0]});
         if (k[0])
            check(first_sd_or_encoder_connector_o, enc_i);
         else
            check(dual_rate_connector_o, star_b_hd_i);
         if (!k[0])
            check(second_sd_or_encoder_connector_o, enc_i);
         if (k == 1)
            check(option_connector_o, enc_i);
         if (k == 2)
            check(option_connector_o, aes_i);
      end
      cmd(`VRC_CMD_AUDIO, 12'h000);
      check(audio_word_bits_o, `VRC_WL_FULL);
      cmd(3'h7, 12'h001);
      check(audio_channels_o, `VRC_CH_FULL);
      cmd(`VRC_CMD_AUDIO, 12'h001);
      check(audio_word_bits_o, `VRC_WL_REDUCED);
      cmd(`VRC_CMD_HPH, 12'h003);
      cmd(`VRC_CMD_VPH, 12'h001);
      frame(1, d0);
      repeat (20) @(negedge mclk_i);
      check(sd_conv_ready_o, 1'b1);
      // fifo drained while timing runs: every switch now shows the sd word
      cmd(`VRC_CMD_OUT, 12'h001);
      check(dual_rate_connector_o, sd_conv_i);
      check(first_sd_or_encoder_connector_o, sd_conv_i);
      check(second_sd_or_encoder_connector_o, sd_conv_i);
      check(option_connector_o, sd_conv_i);
      check(enc_feed_o, sd_conv_i);
      cmd(`VRC_CMD_HFINE, 12'h002);
      frame(1, d1);
      check(12'(d1 - d0), 12'h002);
      cmd(`VRC_CMD_HFINE, 12'h000);
      cmd(`VRC_CMD_HPH, 12'h005);
      frame(1, d1);
      check(12'(d1 - d0), 12'h002);
      cmd(`VRC_CMD_HPH, 12'h003);
      cmd(`VRC_CMD_VPH, 12'h002);
      frame(2, d1);
      check(12'(d1), 12'(d0));
      check(early, 1'b0);
      // delayed line mark follows a line mark by the coarse offset
      d1 = 0;
      sol_i = 1'b1;
      @(negedge mclk_i) sol_i = 1'b0;
      while (!sol_o && d1 < 60)
         @(negedge mclk_i) d1++;
      check(12'(d1), 12'h003);
      final_report();
   end
endmodule
